// ===== hw/accel_core.sv
// Accelerometer mode control, serial register slave and sample formatting
`timescale 1ns/1ns
// Behaviour
// RQ1: Active bit clear: standby, analog off, sample clock stopped, serial slave still answers.
// RQ2: Active bit set: analog and digital enabled, sampling while serial slave serves.
// RQ3: Active to standby keeps every register value.
// RQ4: Standby to active clears output sample registers, others untouched.
// RQ5: Sleep and wake are sub-states of active, sleep never entered from standby.
// RQ6: Slave never holds the serial clock low; master sets clock timing.
// RQ7: One g is 256, 128 or 64 counts for 2g, 4g, 8g ranges.
// RQ8: Samples are two's complement in output registers starting at 0x00.
// RQ9: Self-test output is real reading plus test force, scaled by range.
// RQ10: Host changes mode by serial write, configures only in standby; the code accepts range and self-test writes in every mode.
// RQ11: New active bit takes effect at the end of its write transfer.
module accel_core #(
  parameter int WAKE_DIV = accel_pkg::WAKE_CYCLES,
  parameter int SLEEP_DIV = accel_pkg::SLEEP_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire accel_pkg::accel_raw_s raw_in,
  input wire logic sleep_req_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic analog_en_out,
  output logic sample_run_out,
  output accel_pkg::mode_e mode_out
);
  logic scl_s, sda_s, scl_d, sda_d;
  logic start_ev, stop_ev, scl_rise, scl_fall;
  accel_pkg::ser_state_e state;
  logic [3:0] bit_cnt;
  logic [7:0] shift, tx, ptr, wr_data, rd_byte;
  logic rw, is_ptr, master_nack, wr_stb;
  logic active, active_pend, selftest;
  logic [1:0] rng;
  logic [16:0] tick_cnt;
  logic tick;
  accel_pkg::accel_out_s data;

  // ---------------------------------------------------------------
  // Pin sampling and bus condition detect
  // ---------------------------------------------------------------
  sync_2ff #(.RST_VAL(1'b1)) u_sync_scl (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .d_in(scl_in), .q_out(scl_s)
  );
  sync_2ff #(.RST_VAL(1'b1)) u_sync_sda (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .d_in(sda_in), .q_out(sda_s)
  );

  // Previous levels for edge finding
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else if (ce_in) begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Start and stop are data edges while the clock stays high
  assign start_ev = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_ev = scl_s & scl_d & ~sda_d & sda_s;
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;

  // ---------------------------------------------------------------
  // Serial slave
  // ---------------------------------------------------------------
  // Read data mux, output bytes are the sample bits left aligned
  always_comb begin
    unique case (ptr)
      accel_pkg::REG_OUT_XM: rd_byte = data.x[9:2]; // RQ8
      accel_pkg::REG_OUT_XL: rd_byte = {data.x[1:0], 6'h00};
      accel_pkg::REG_OUT_YM: rd_byte = data.y[9:2];
      accel_pkg::REG_OUT_YL: rd_byte = {data.y[1:0], 6'h00};
      accel_pkg::REG_OUT_ZM: rd_byte = data.z[9:2];
      accel_pkg::REG_OUT_ZL: rd_byte = {data.z[1:0], 6'h00};
      accel_pkg::REG_RANGE: rd_byte = {6'h00, rng};
      accel_pkg::REG_CTRL1: rd_byte = {7'h00, active};
      accel_pkg::REG_CTRL2: rd_byte = {selftest, 7'h00};
      default: rd_byte = 8'h00;
    endcase
  end

  // Bit engine; only SDA is ever pulled, SCL has no driver at all
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= accel_pkg::SER_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      tx <= 8'hFF;
      ptr <= 8'h00;
      rw <= 1'b0;
      is_ptr <= 1'b0;
      master_nack <= 1'b0;
      wr_stb <= 1'b0;
      wr_data <= 8'h00;
      sda_oe_out <= 1'b0;
      sda_out <= 1'b0;
    end else if (ce_in) begin
      wr_stb <= 1'b0;
      sda_out <= 1'b0; // RQ6
      if (start_ev) begin
        state <= accel_pkg::SER_ADDR;
        bit_cnt <= 4'h0;
        is_ptr <= 1'b1;
        sda_oe_out <= 1'b0;
      end else if (stop_ev) begin
        state <= accel_pkg::SER_IDLE;
        sda_oe_out <= 1'b0;
      end else if (scl_rise) begin
        if (state == accel_pkg::SER_ADDR || state == accel_pkg::SER_WR) begin
          shift <= {shift[6:0], sda_s};
          bit_cnt <= bit_cnt + 4'h1;
        end else if (state == accel_pkg::SER_RD) begin
          bit_cnt <= bit_cnt + 4'h1;
        end else if (state == accel_pkg::SER_ACK_R) begin
          master_nack <= sda_s;
        end
      end else if (scl_fall) begin
        unique case (state)
          accel_pkg::SER_ADDR: begin
            if (bit_cnt == 4'h8) begin
              if (shift[7:1] == accel_pkg::DEV_ADDR) begin
                state <= accel_pkg::SER_ACK_A;
                rw <= shift[0];
                sda_oe_out <= 1'b1;
              end else begin
                state <= accel_pkg::SER_SKIP;
              end
            end
          end
          accel_pkg::SER_ACK_A: begin
            bit_cnt <= 4'h0;
            if (rw) begin
              state <= accel_pkg::SER_RD;
              tx <= rd_byte;
              sda_oe_out <= ~rd_byte[7];
            end else begin
              state <= accel_pkg::SER_WR;
              sda_oe_out <= 1'b0;
            end
          end
          accel_pkg::SER_WR: begin
            if (bit_cnt == 4'h8) begin
              state <= accel_pkg::SER_ACK_W;
              sda_oe_out <= 1'b1;
              is_ptr <= 1'b0;
              if (is_ptr) begin
                ptr <= shift;
              end else begin
                wr_stb <= 1'b1;
                wr_data <= shift;
                ptr <= ptr + 8'h01;
              end
            end
          end
          accel_pkg::SER_ACK_W: begin
            state <= accel_pkg::SER_WR;
            bit_cnt <= 4'h0;
            sda_oe_out <= 1'b0;
          end
          accel_pkg::SER_RD: begin
            if (bit_cnt == 4'h8) begin
              state <= accel_pkg::SER_ACK_R;
              sda_oe_out <= 1'b0;
              ptr <= ptr + 8'h01;
            end else begin
              tx <= {tx[6:0], 1'b1};
              sda_oe_out <= ~tx[6];
            end
          end
          accel_pkg::SER_ACK_R: begin
            bit_cnt <= 4'h0;
            if (master_nack) begin
              state <= accel_pkg::SER_SKIP;
            end else begin
              state <= accel_pkg::SER_RD;
              tx <= rd_byte;
              sda_oe_out <= ~rd_byte[7];
            end
          end
          accel_pkg::SER_IDLE, accel_pkg::SER_SKIP: begin
            sda_oe_out <= 1'b0;
          end
        endcase
      end
    end
  end

  // Write strobe targets the pointer value before its increment
  logic [7:0] wr_addr;
  assign wr_addr = ptr - 8'h01;

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  // Active bit is staged and committed when the transfer ends
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      active <= accel_pkg::CTRL_BIT_RST;
      active_pend <= accel_pkg::CTRL_BIT_RST;
      selftest <= accel_pkg::CTRL_BIT_RST;
      rng <= accel_pkg::RANGE_RST;
    end else if (ce_in) begin
      if (wr_stb && wr_addr == accel_pkg::REG_CTRL1) begin
        active_pend <= wr_data[accel_pkg::CTRL1_ACTIVE_BIT];
      end
      if (wr_stb && wr_addr == accel_pkg::REG_CTRL2) begin
        selftest <= wr_data[accel_pkg::CTRL2_SELFTEST_BIT];
      end
      if (wr_stb && wr_addr == accel_pkg::REG_RANGE) begin
        rng <= wr_data[1:0];
      end
      if (stop_ev || start_ev) begin
        active <= active_pend; // RQ11
      end
    end
  end

  // ---------------------------------------------------------------
  // Mode control
  // ---------------------------------------------------------------
  // Standby, wake and sleep; sleep only reachable through wake
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_out <= accel_pkg::MODE_STANDBY;
      analog_en_out <= 1'b0;
      sample_run_out <= 1'b0;
    end else if (ce_in) begin
      analog_en_out <= active; // RQ1 RQ2
      sample_run_out <= active; // RQ1
      unique case (mode_out)
        accel_pkg::MODE_STANDBY: begin
          if (active) begin
            mode_out <= accel_pkg::MODE_WAKE; // RQ5
          end
        end
        accel_pkg::MODE_WAKE: begin
          if (!active) begin
            mode_out <= accel_pkg::MODE_STANDBY;
          end else if (sleep_req_in) begin
            mode_out <= accel_pkg::MODE_SLEEP;
          end
        end
        accel_pkg::MODE_SLEEP: begin
          if (!active) begin
            mode_out <= accel_pkg::MODE_STANDBY;
          end else if (!sleep_req_in) begin
            mode_out <= accel_pkg::MODE_WAKE;
          end
        end
        default: mode_out <= accel_pkg::MODE_STANDBY;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Sampling
  // ---------------------------------------------------------------
  // Sample rate divider, held at zero while standby stops the clocks
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_cnt <= 17'h00000;
      tick <= 1'b0;
    end else if (ce_in) begin
      tick <= 1'b0;
      if (mode_out == accel_pkg::MODE_STANDBY) begin
        tick_cnt <= 17'h00000; // RQ1
      end else if (tick_cnt >= 17'((mode_out == accel_pkg::MODE_SLEEP ? SLEEP_DIV : WAKE_DIV) - 1)) begin
        tick_cnt <= 17'h00000;
        tick <= 1'b1;
      end else begin
        tick_cnt <= tick_cnt + 17'h00001;
      end
    end
  end

  // Adds self-test force, divides by range and clips to ten bits
  function automatic logic signed [9:0] scale(input logic signed [13:0] raw,
      input logic signed [13:0] force_v, input logic st_en, input logic [1:0] range_v);
    logic signed [14:0] sum;
    logic signed [14:0] sh;
    sum = 15'(raw) + (st_en ? 15'(force_v) : 15'sh0000); // RQ9
    sh = sum >>> ((range_v == accel_pkg::RANGE_2G) ? 0 :
                  (range_v == accel_pkg::RANGE_4G) ? 1 : 2); // RQ7
    if (sh > 15'sh01FF) begin
      scale = 10'sh1FF;
    end else if (sh < -15'sh0200) begin
      scale = -10'sh200;
    end else begin
      scale = sh[9:0];
    end
  endfunction

  // Output samples: cleared on entry to active, kept on return to standby
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      data <= '0;
    end else if (ce_in) begin
      if (mode_out == accel_pkg::MODE_STANDBY && active) begin
        data <= '0; // RQ4
      end else if (tick && mode_out != accel_pkg::MODE_STANDBY && active) begin // RQ3
        data.x <= scale(raw_in.x, accel_pkg::SELFTEST_X, selftest, rng); // RQ8
        data.y <= scale(raw_in.y, accel_pkg::SELFTEST_Y, selftest, rng);
        data.z <= scale(raw_in.z, accel_pkg::SELFTEST_Z, selftest, rng);
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_standby_quiet: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ1
    ce_in && !active |=> !analog_en_out && !sample_run_out) else $error("standby not quiet");
  a_active_wakes: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ2
    ce_in && $rose(active) ##1 ce_in |=> mode_out == accel_pkg::MODE_WAKE && analog_en_out)
    else $error("active did not wake");
  a_stop_keeps: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ3
    ce_in && mode_out != accel_pkg::MODE_STANDBY && !active
    |=> $stable(data) && $stable(rng) && $stable(selftest))
    else $error("standby changed registers");
  a_start_clears: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ4
    ce_in && mode_out == accel_pkg::MODE_STANDBY && active |=> data == '0 && $stable(rng))
    else $error("entry to active did not clear samples");
  a_no_sleep_stby: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ5
    mode_out == accel_pkg::MODE_STANDBY |=> mode_out != accel_pkg::MODE_SLEEP)
    else $error("sleep entered from standby");
  a_pull_only: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ6
    sda_out == 1'b0) else $error("sda driven high");
  a_scale_8g: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ7
    ce_in && tick && mode_out != accel_pkg::MODE_STANDBY && active && !selftest
    && rng == accel_pkg::RANGE_8G
    |=> data.x == 10'(($past(raw_in.x) >>> 2))) else $error("8g scale wrong");
  a_read_x: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ8
    ptr == accel_pkg::REG_OUT_XM |-> rd_byte == data.x[9:2]) else $error("x msb mux");
  a_selftest_add: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ9
    ce_in && tick && mode_out != accel_pkg::MODE_STANDBY && active && selftest
    && rng == accel_pkg::RANGE_2G && raw_in.x > -14'sh0100 && raw_in.x < 14'sh0100
    |=> data.x == 10'($past(raw_in.x) + accel_pkg::SELFTEST_X)) else $error("self-test sum");
  a_commit_end: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ11
    $changed(active) |-> $past(start_ev || stop_ev)) else $error("active changed mid transfer");
endmodule // accel_core

// ===== hw/accel_pkg.sv
// Shared constants and types for the accelerometer mode and output block
package accel_pkg;
  // ---------------------------------------------------------------
  // Serial slave address and register offsets
  // ---------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR = 7'h1C;
  localparam logic [7:0] REG_OUT_XM = 8'h00;
  localparam logic [7:0] REG_OUT_XL = 8'h01;
  localparam logic [7:0] REG_OUT_YM = 8'h02;
  localparam logic [7:0] REG_OUT_YL = 8'h03;
  localparam logic [7:0] REG_OUT_ZM = 8'h04;
  localparam logic [7:0] REG_OUT_ZL = 8'h05;
  localparam logic [7:0] REG_RANGE = 8'h0E;
  localparam logic [7:0] REG_CTRL1 = 8'h2A;
  localparam logic [7:0] REG_CTRL2 = 8'h2B;
  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int CTRL1_ACTIVE_BIT = 0;
  localparam int CTRL2_SELFTEST_BIT = 7;
  localparam logic [1:0] RANGE_2G = 2'h0;
  localparam logic [1:0] RANGE_4G = 2'h1;
  localparam logic [1:0] RANGE_8G = 2'h2;
  localparam logic [1:0] RANGE_RST = 2'h0;
  localparam logic CTRL_BIT_RST = 1'b0;
  // Self-test force per axis, in 2g-range counts (256 per g)
  localparam logic signed [13:0] SELFTEST_X = 14'sh0016;
  localparam logic signed [13:0] SELFTEST_Y = 14'sh0020;
  localparam logic signed [13:0] SELFTEST_Z = 14'sh00D2;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int WAKE_PERIOD_NS = 10000;
  localparam int SLEEP_PERIOD_NS = 640000;
  localparam int WAKE_CYCLES = WAKE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SLEEP_CYCLES = SLEEP_PERIOD_NS / CLK_PERIOD_NS;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_STANDBY = 2'h0,
    MODE_WAKE = 2'h1,
    MODE_SLEEP = 2'h3
  } mode_e;
  typedef enum logic [2:0] {
    SER_IDLE = 3'h0,
    SER_ADDR = 3'h1,
    SER_ACK_A = 3'h3,
    SER_WR = 3'h2,
    SER_ACK_W = 3'h6,
    SER_RD = 3'h7,
    SER_ACK_R = 3'h5,
    SER_SKIP = 3'h4
  } ser_state_e;
  typedef struct packed {
    logic signed [13:0] x;
    logic signed [13:0] y;
    logic signed [13:0] z;
  } accel_raw_s;
  typedef struct packed {
    logic signed [9:0] x;
    logic signed [9:0] y;
    logic signed [9:0] z;
  } accel_out_s;
endpackage

// ===== hw/sync_2ff.sv
// Two flip-flop synchroniser for a level from another clock domain
`timescale 1ns/1ns
module sync_2ff #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic d_in,
  output logic q_out
);
  logic meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta <= RST_VAL;
      q_out <= RST_VAL;
    end else if (ce_in) begin
      meta <= d_in;
      q_out <= meta;
    end
  end
endmodule // sync_2ff

// ===== tb/i2c_host_model.sv
// Serial bus master model that drives the accelerometer slave port
`timescale 1ns/1ns
module i2c_host_model (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out,
  output logic rd_stb_out,
  output logic [7:0] rd_byte_out
);
  // ---------------------------------------------------------------
  // Bus primitives, 16 clk per bit, lines idle high
  // ---------------------------------------------------------------
  // Only this model moves the serial clock; the slave never holds it
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
    rd_stb_out = 1'b0;
    rd_byte_out = 8'h00;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // Data moves mid-low, read back at the end of the high phase
  task automatic put_bit(input logic b, output logic s);
    hold(4);
    sda_out <= b;
    hold(4);
    scl_out <= 1'b1;
    hold(8);
    s = sda_in;
    scl_out <= 1'b0;
  endtask
  // SDA moves from a to b while SCL is high
  task automatic cond(input logic a, input logic b);
    hold(4);
    sda_out <= a;
    hold(4);
    scl_out <= 1'b1;
    hold(8);
    sda_out <= b;
    hold(8);
  endtask
  task automatic start();
    cond(1'b1, 1'b0);
    scl_out <= 1'b0;
  endtask
  task automatic stop();
    cond(1'b0, 1'b1);
  endtask
  // Byte out MSB first; nack is the level seen in the ninth bit
  task automatic wr_byte(input logic [7:0] b, output logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i], s);
    end
    put_bit(1'b1, nack);
  endtask
  // Byte in with the line released; last answers NACK
  task automatic rd_byte(input logic last);
    logic [7:0] v;
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, v[i]);
    end
    put_bit(last, s);
    rd_byte_out <= v;
    rd_stb_out <= 1'b1;
    hold(1);
    rd_stb_out <= 1'b0;
  endtask
endmodule // i2c_host_model

// ===== tb/accel_core_tb.sv
// Self-checking bench for the accelerometer mode and output block
`timescale 1ns/1ns
module accel_core_tb;
  localparam int WDIV = 1500;
  localparam int SDIV = 2500;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sleep_req = 1'b0;
  accel_pkg::accel_raw_s raw = '0;
  logic sda_oe;
  logic analog_en;
  logic sample_run;
  accel_pkg::mode_e mode;
  logic m_scl;
  logic m_sda;
  logic rd_stb;
  logic [7:0] rd_byte;
  logic sda_wire;
  logic ce = 1'b1;
  logic sda_pull;
  logic [7:0] expq[$];
  logic [7:0] last_b[6];
  logic [31:0] seed = 32'h8D32;
  int err_total = 0;
  int checks_done = 0;
  // Open-drain data line with pull-up
  assign sda_wire = m_sda & (~sda_oe | sda_pull);
  accel_core #(.WAKE_DIV(WDIV), .SLEEP_DIV(SDIV)) dut (
    .clk_in(clk), .rst_n_in(rst_n), .ce_in(ce), .scl_in(m_scl), .sda_in(sda_wire),
    .raw_in(raw), .sleep_req_in(sleep_req), .sda_out(sda_pull), .sda_oe_out(sda_oe),
    .analog_en_out(analog_en), .sample_run_out(sample_run), .mode_out(mode)
  );
  i2c_host_model host (
    .clk_in(clk), .sda_in(sda_wire), .scl_out(m_scl), .sda_out(m_sda),
    .rd_stb_out(rd_stb), .rd_byte_out(rd_byte)
  );
  // 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Takes the oldest expected byte whenever the host returns one
  always @(posedge clk) begin
    if (rd_stb === 1'b1) begin
      if (expq.size() == 0) begin
        err_total++;
        $display("mismatch read byte expected none seen %h", rd_byte);
      end else begin
        chk("read byte", expq.pop_front(), rd_byte);
      end
    end
  end
  task automatic wr_reg(input logic [7:0] ptr, input logic [7:0] d, input logic fin);
    logic n0;
    logic n1;
    logic n2;
    host.start();
    host.wr_byte({accel_pkg::DEV_ADDR, 1'b0}, n0);
    host.wr_byte(ptr, n1);
    host.wr_byte(d, n2);
    chk("write ack", 8'h00, 8'({n0, n1, n2}));
    if (fin)
      host.stop();
  endtask
  // Pointer write, repeated START, n bytes, NACK on the last
  task automatic rd_regs(input logic [7:0] ptr, input int n);
    logic nk;
    host.start();
    host.wr_byte({accel_pkg::DEV_ADDR, 1'b0}, nk);
    host.wr_byte(ptr, nk);
    host.start();
    host.wr_byte({accel_pkg::DEV_ADDR, 1'b1}, nk);
    for (int i = 0; i < n; i++) begin
      host.rd_byte(i == n - 1);
    end
    host.stop();
  endtask
  function automatic logic [9:0] scale(input logic signed [13:0] r,
                                       input logic signed [13:0] f, input logic [1:0] rg);
    logic signed [15:0] s;
    s = r;
    s = s + f;
    s = s >>> rg;
    if (s > 16'sh01FF)
      s = 16'sh01FF;
    if (s < -16'sh0200)
      s = -16'sh0200;
    return s[9:0];
  endfunction
  // Queues the six output bytes for the present raw input
  task automatic exp_sample(input logic st, input logic [1:0] rg);
    logic [9:0] v[3];
    v[0] = scale(raw.x, st ? accel_pkg::SELFTEST_X : 14'sh0000, rg);
    v[1] = scale(raw.y, st ? accel_pkg::SELFTEST_Y : 14'sh0000, rg);
    v[2] = scale(raw.z, st ? accel_pkg::SELFTEST_Z : 14'sh0000, rg);
    for (int a = 0; a < 3; a++) begin
      last_b[2 * a] = v[a][9:2];
      last_b[2 * a + 1] = {v[a][1:0], 6'h00};
    end
    for (int i = 0; i < 6; i++) begin
      expq.push_back(last_b[i]);
    end
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic new_raw();
    repeat (11) seed = lfsr(seed);
    raw <= {14'($signed(seed[9:0])), 14'($signed(seed[19:10])), 14'($signed(seed[29:20]))};
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Cuts a hang short
  initial begin
    hold(80000);
    err_total++;
    test_done();
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic nk;
    logic [1:0] rg;
    hold(2);
    rst_n <= 1'b1;
    hold(3);
    sleep_req <= 1'b1;
    hold(4);
    chk("mode", 8'(accel_pkg::MODE_STANDBY), 8'(mode));
    chk("outputs", 8'h00, 8'({analog_en, sample_run, sda_oe}));
    chk("sda level", 8'h00, 8'(sda_pull));
    expq.push_back(8'h00);
    expq.push_back(8'h00);
    rd_regs(accel_pkg::REG_CTRL1, 2);
    chk("mode", 8'(accel_pkg::MODE_STANDBY), 8'(mode));
    sleep_req <= 1'b0;
    host.start();
    host.wr_byte({accel_pkg::DEV_ADDR ^ 7'h01, 1'b0}, nk);
    chk("foreign address ack", 8'h01, 8'(nk));
    host.stop();
    $display("test standby done");
    wr_reg(accel_pkg::REG_CTRL1, 8'h01, 1'b0);
    chk("active before stop", 8'h00, 8'({analog_en, mode}));
    host.stop();
    chk("active after stop", 8'h0D, 8'({analog_en, sample_run, mode}));
    $display("test activate done");
    for (int c = 0; c < 6; c++) begin
      rg = 2'(c / 2);
      wr_reg(accel_pkg::REG_CTRL1, 8'h00, 1'b1);
      wr_reg(accel_pkg::REG_RANGE, 8'(rg), 1'b1);
      wr_reg(accel_pkg::REG_CTRL2, {c[0], 7'h00}, 1'b1);
      new_raw();
      wr_reg(accel_pkg::REG_CTRL1, 8'h01, 1'b1);
      hold(WDIV + 20);
      exp_sample(c[0], rg);
      rd_regs(accel_pkg::REG_OUT_XM, 6);
    end
    $display("test ranges done");
    wr_reg(accel_pkg::REG_CTRL1, 8'h00, 1'b1);
    chk("standby", 8'h00, 8'({analog_en, sample_run, mode}));
    new_raw();
    hold(WDIV + 20);
    for (int i = 0; i < 6; i++) begin
      expq.push_back(last_b[i]);
    end
    expq.push_back(8'h02);
    rd_regs(accel_pkg::REG_OUT_XM, 6);
    rd_regs(accel_pkg::REG_RANGE, 1);
    $display("test retention done");
    wr_reg(accel_pkg::REG_CTRL1, 8'h01, 1'b1);
    expq.push_back(8'h00);
    expq.push_back(8'h00);
    expq.push_back(8'h80);
    rd_regs(accel_pkg::REG_OUT_XM, 2);
    rd_regs(accel_pkg::REG_CTRL2, 1);
    $display("test subset reset done");
    sleep_req <= 1'b1;
    hold(3);
    chk("sleep", 8'(accel_pkg::MODE_SLEEP), 8'(mode));
    // Clock enable low must freeze the mode even when sleep is withdrawn
    ce <= 1'b0;
    sleep_req <= 1'b0;
    hold(4);
    chk("frozen mode", 8'(accel_pkg::MODE_SLEEP), 8'(mode));
    ce <= 1'b1;
    sleep_req <= 1'b1;
    hold(SDIV + 20);
    exp_sample(1'b1, 2'h2);
    rd_regs(accel_pkg::REG_OUT_XM, 6);
    sleep_req <= 1'b0;
    wr_reg(accel_pkg::REG_CTRL1, 8'h00, 1'b1);
    chk("mode", 8'(accel_pkg::MODE_STANDBY), 8'(mode));
    hold(20);
    chk("bytes left", 8'h00, 8'(expq.size()));
    $display("test sleep done");
    test_done();
  end
endmodule // accel_core_tb
